// file: hw/bpt_pkg.sv
/*
  Constants, types and mode encodings for the six-channel buffered PWM timer.
  Assumes a single 40 MHz clock and that software-facing bits arrive as plain ports.
*/
// Operation
// R1: Toggle-on-wrap inverts the channel pin each time the counter reaches the limit.
// R2: A match between counter and channel value ends the pulse.
// R3: Limit 255 with undivided clock gives a 256-cycle period.
// R4: Match value 128 in a 256-step period gives half duty.
// R5: Unbuffered compare uses only the live value; missed matches are not recovered.
// R6: Match event ends the pulse; wrap event ends the period.
// R7: Software writes shorter widths from the match event handler.
// R8: Software writes longer widths from the wrap event handler.
// R9: Software avoids toggle-on-match for PWM channels.
// R10: Software picks clear or set so the match forces the idle level.
// R11: Link bit on an even channel pairs it with the next odd channel.
// R12: Even value leads first; at each wrap the last-written value takes over.
// R13: Linked pair is governed by the even channel; odd pin is released.
// R14: Software must not rewrite the active value of a linked pair.
// R15: Software follows halt, reset, limit, width, mode, then unhalt order.
// R16: Mode select 01 is single compare, 10 is linked buffered on even channel.
// R17: Action select 10 clears on match, 11 sets on match.
// R18: Upper mode bit set overrides the lower bit.
// R19: Toggle-on-wrap cleared gives constant output, zero duty.
// R20: Full-duty bit with toggle-on-wrap gives constant full duty.
// R21: Counter reset clears counter and divider and restarts from zero.
// R22: Halt stops counting and is set by reset.
// R23: Divider select picks 1 to 64 or an external tick for code 111.
// R24: Wrap flag sets on reaching the limit; an enable gates the request.
// R25: Counter wraps to zero on the tick after reaching the limit.
`default_nettype none
package bpt_pkg;
  localparam int NUM_CH = 6;
  localparam int CNT_W = 16;
  localparam int DIV_W = 7;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [DIV_W-1:0] DIV_ZERO = 7'h00;
  localparam logic [2:0] DIV_EXT = 3'h7;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam int MODE_LINK_BIT = 1;
  localparam int MODE_SINGLE_BIT = 0;
  localparam int ACT_ENABLE_BIT = 1;
  localparam int ACT_LEVEL_BIT = 0;
  typedef logic [CNT_W-1:0] bpt_cnt_t;
endpackage : bpt_pkg
`default_nettype wire

// file: hw/bpt_tick_if.sv
/*
  Interface carrying the prescaled tick and counter state to the channels.
  Assumes one clock domain.
*/
`default_nettype none
interface bpt_tick_if;
  import bpt_pkg::*;
  logic tick;
  logic wrap;
  bpt_cnt_t count;
  modport src (output tick, output wrap, output count);
  modport dst (input tick, input wrap, input count);
endinterface : bpt_tick_if
`default_nettype wire

// file: hw/bpt_counter.sv
/*
  Shared prescaler and modulo counter.
  Assumes the external tick input is already synchronous to core_clk_i.
*/
`default_nettype none
module bpt_counter
  import bpt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic counter_halt_i,
  input wire logic counter_reset_i,
  input wire logic [2:0] clock_divider_select_i,
  input wire logic ext_tick_i,
  input wire bpt_cnt_t period_limit_value_i,
  bpt_tick_if.src tk
);
  logic [DIV_W-1:0] div_q;
  bpt_cnt_t cnt_q;
  logic [DIV_W-1:0] div_mask;
  logic tick_w;
  logic at_limit;
  // ----------------------------------------
  // Divider
  // ----------------------------------------
  assign div_mask = DIV_W'((8'h01 << clock_divider_select_i) - 8'h01);
  assign tick_w = !counter_halt_i && ((clock_divider_select_i == DIV_EXT) ? ext_tick_i :
                  ((div_q & div_mask) == DIV_ZERO)); // R23
  assign at_limit = (cnt_q == period_limit_value_i);
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || counter_reset_i) begin
      div_q <= DIV_ZERO; // R21
      cnt_q <= CNT_ZERO; // R21
    end else if (!counter_halt_i) begin // R22
      div_q <= div_q + DIV_W'(1);
      if (tick_w) begin
        cnt_q <= at_limit ? CNT_ZERO : cnt_q + CNT_W'(1); // R25 R3
      end
    end
  end
  assign tk.tick = tick_w && !counter_reset_i;
  assign tk.wrap = tick_w && !counter_reset_i && at_limit; // R24
  assign tk.count = cnt_q;
endmodule : bpt_counter
`default_nettype wire

// file: hw/bpt_top.sv
/*
  Six-channel PWM timer top: counter, per-channel compare, pair buffering.
  Assumes all control bits are static ports driven by the surrounding core.
*/
`default_nettype none
module bpt_top
  import bpt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic counter_halt_set_i,
  input wire logic counter_halt_clr_i,
  input wire logic counter_reset_i,
  input wire logic [2:0] clock_divider_select_i,
  input wire logic ext_tick_i,
  input wire bpt_cnt_t period_limit_value_i,
  input wire logic wrap_irq_enable_i,
  input wire logic wrap_flag_clr_i,
  input wire logic [NUM_CH-1:0] match_write_i,
  input wire bpt_cnt_t match_wdata_i,
  input wire logic [NUM_CH*2-1:0] mode_select_i,
  input wire logic [NUM_CH*2-1:0] compare_action_select_i,
  input wire logic [NUM_CH-1:0] toggle_on_wrap_i,
  input wire logic [NUM_CH-1:0] full_duty_enable_i,
  input wire logic [NUM_CH-1:0] match_irq_enable_i,
  input wire logic [NUM_CH-1:0] match_flag_clr_i,
  output logic counter_halt_o,
  output bpt_cnt_t count_o,
  output logic wrap_flag_o,
  output logic wrap_irq_o,
  output logic [NUM_CH-1:0] match_flag_o,
  output logic [NUM_CH-1:0] match_irq_o,
  output logic [NUM_CH-1:0] channel_pin_o,
  output logic [NUM_CH-1:0] channel_pin_oe_o,
  output logic [NUM_CH/2-1:0] pair_active_odd_o
);
  bpt_tick_if tk ();
  logic halt_q;
  logic wrap_flag_q;
  logic [NUM_CH-1:0] match_flag_q;
  logic [NUM_CH-1:0] pin_q;
  logic [NUM_CH/2-1:0] act_odd_q;
  logic [NUM_CH/2-1:0] pend_odd_q;
  bpt_cnt_t match_q [NUM_CH];
  logic [NUM_CH-1:0] linked;
  logic [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0] out_en;
  bpt_cnt_t cnt_next;
  function automatic logic pair_linked(input logic [NUM_CH*2-1:0] ms, input int ch);
    pair_linked = ms[(ch - ch % 2) * 2 + MODE_LINK_BIT];
  endfunction : pair_linked
  // ----------------------------------------
  // Counter
  // ----------------------------------------
  bpt_counter u_cnt (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .counter_halt_i(halt_q),
    .counter_reset_i(counter_reset_i),
    .clock_divider_select_i(clock_divider_select_i),
    .ext_tick_i(ext_tick_i),
    .period_limit_value_i(period_limit_value_i),
    .tk(tk)
  );
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      halt_q <= 1'b1; // R22
    end else if (counter_halt_set_i) begin
      halt_q <= 1'b1;
    end else if (counter_halt_clr_i) begin
      halt_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // Wrap flag, set wins over clear
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wrap_flag_q <= 1'b0;
    end else if (tk.wrap) begin
      wrap_flag_q <= 1'b1; // R24 R6
    end else if (wrap_flag_clr_i) begin
      wrap_flag_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // Channel values and pair selection
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (sys_rst_i) begin
        match_q[c] <= CNT_ZERO;
      end else if (match_write_i[c]) begin
        match_q[c] <= match_wdata_i; // R5
      end
    end
  end
  always_ff @(posedge core_clk_i) begin
    for (int p = 0; p < NUM_CH/2; p++) begin
      if (sys_rst_i || !linked[2*p]) begin
        act_odd_q[p] <= 1'b0; // R12
        pend_odd_q[p] <= 1'b0;
      end else begin
        if (match_write_i[2*p+1]) begin
          pend_odd_q[p] <= 1'b1; // R12
        end else if (match_write_i[2*p]) begin
          pend_odd_q[p] <= 1'b0;
        end
        if (tk.wrap) begin
          act_odd_q[p] <= match_write_i[2*p+1] ? 1'b1 :
                          match_write_i[2*p] ? 1'b0 : pend_odd_q[p]; // R12
        end
      end
    end
  end
  // ----------------------------------------
  // Compare decode
  // ----------------------------------------
  // Match on the count about to be taken, so a width of N spans exactly N ticks
  assign cnt_next = tk.wrap ? CNT_ZERO : tk.count + CNT_W'(1); // R4 R25
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int E = c - c % 2;
    wire logic lk = pair_linked(mode_select_i, c); // R11 R18
    wire bpt_cnt_t val = (lk && act_odd_q[c/2]) ? match_q[E+1] : match_q[E]; // R12
    wire logic [1:0] md = mode_select_i[2*c +: 2];
    assign linked[c] = lk;
    assign out_en[c] = (c % 2 == 0) ? (lk || md[MODE_SINGLE_BIT]) :
                       (!lk && md[MODE_SINGLE_BIT]); // R13 R16
    assign hit[c] = tk.tick && out_en[c] &&
                    (cnt_next == (lk ? val : match_q[c])); // R2 R4 R5
  end
  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (sys_rst_i) begin
        pin_q[c] <= 1'b0;
        match_flag_q[c] <= 1'b0;
      end else begin
        if (hit[c]) begin
          match_flag_q[c] <= 1'b1; // R6
        end else if (match_flag_clr_i[c]) begin
          match_flag_q[c] <= 1'b0;
        end
        if (!out_en[c]) begin
          pin_q[c] <= pin_q[c];
        end else if (toggle_on_wrap_i[c] && full_duty_enable_i[c]) begin
          pin_q[c] <= !compare_action_select_i[2*c + ACT_LEVEL_BIT]; // R20
        end else if (tk.wrap && toggle_on_wrap_i[c]) begin
          pin_q[c] <= !pin_q[c]; // R1 R19
        end else if (hit[c] && compare_action_select_i[2*c + ACT_ENABLE_BIT]) begin
          pin_q[c] <= compare_action_select_i[2*c + ACT_LEVEL_BIT]; // R17 R2
        end else if (hit[c] && compare_action_select_i[2*c +: 2] == ACT_TOGGLE) begin
          pin_q[c] <= !pin_q[c];
        end
      end
    end
  end
  assign counter_halt_o = halt_q;
  assign count_o = tk.count;
  assign wrap_flag_o = wrap_flag_q;
  assign wrap_irq_o = wrap_flag_q && wrap_irq_enable_i; // R24
  assign match_flag_o = match_flag_q;
  assign match_irq_o = match_flag_q & match_irq_enable_i; // R6
  assign channel_pin_o = pin_q;
  assign channel_pin_oe_o = out_en; // R13
  assign pair_active_odd_o = act_odd_q;
endmodule : bpt_top
`default_nettype wire

// file: bench/bpt_checker.sv
/* Port assertions for the PWM timer top.
   Bound into bpt_top; one clock, sync reset. */
`default_nettype none
module bpt_checker
  import bpt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic counter_halt_set_i,
  input wire logic counter_halt_clr_i,
  input wire logic counter_reset_i,
  input wire logic [2:0] clock_divider_select_i,
  input wire bpt_cnt_t period_limit_value_i,
  input wire logic wrap_irq_enable_i,
  input wire logic [NUM_CH*2-1:0] mode_select_i,
  input wire logic [NUM_CH*2-1:0] compare_action_select_i,
  input wire logic [NUM_CH-1:0] toggle_on_wrap_i,
  input wire logic [NUM_CH-1:0] full_duty_enable_i,
  input wire logic counter_halt_o,
  input wire bpt_cnt_t count_o,
  input wire logic wrap_flag_o,
  input wire logic wrap_irq_o,
  input wire logic [NUM_CH-1:0] channel_pin_o,
  input wire logic [NUM_CH-1:0] channel_pin_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Undivided counting only, so each edge is one tick
  wire logic run = !counter_halt_o && !counter_halt_set_i && !counter_reset_i
    && clock_divider_select_i == 3'h0;
  wire logic wrap_ev = run && count_o == period_limit_value_i;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_step;
    run && count_o < period_limit_value_i |=> count_o == $past(count_o) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("count did not step");
  property p_wrap;
    wrap_ev |=> count_o == CNT_ZERO && wrap_flag_o;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to zero");
  property p_hold;
    counter_halt_o && !counter_halt_clr_i && !counter_reset_i |=> $stable(count_o);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while halted");
  property p_clr;
    counter_reset_i |=> count_o == CNT_ZERO;
  endproperty
  a_clr: assert property (p_clr) else $error("counter reset missed");
  property p_irq;
    wrap_irq_o == (wrap_flag_o && wrap_irq_enable_i);
  endproperty
  a_irq: assert property (p_irq) else $error("wrap request wrong");
  property p_tog;
    wrap_ev && toggle_on_wrap_i[0] && !full_duty_enable_i[0] && channel_pin_oe_o[0]
      |=> channel_pin_o[0] != $past(channel_pin_o[0]);
  endproperty
  a_tog: assert property (p_tog) else $error("pin did not toggle at wrap");
  property p_full;
    full_duty_enable_i[4] && toggle_on_wrap_i[4] && $past(full_duty_enable_i[4])
      |-> channel_pin_o[4] == !compare_action_select_i[8];
  endproperty
  a_full: assert property (p_full) else $error("full duty level wrong");
  property p_odd;
    mode_select_i[1] |-> !channel_pin_oe_o[1];
  endproperty
  a_odd: assert property (p_odd) else $error("odd pin still driven");
endmodule : bpt_checker
bind bpt_top bpt_checker bpt_checker_i (.*);
`default_nettype wire

// file: bench/bpt_load.sv
/* Load on the six channel pins: counts high cycles per pin.
   Assumes a pull-up, so a released pin reads high. */
`default_nettype none
module bpt_load
  import bpt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic clr_i,
  input wire logic [NUM_CH-1:0] pin_i,
  input wire logic [NUM_CH-1:0] oe_i,
  output int high_o [NUM_CH]
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic [NUM_CH-1:0] lvl = (pin_i & oe_i) | ~oe_i;
  always @(posedge core_clk_i) begin
    for (int c = 0; c < NUM_CH; c++) high_o[c] <= clr_i ? 0 : high_o[c] + int'(lvl[c]);
  end
endmodule : bpt_load
`default_nettype wire

// file: bench/test_bpt_top.sv
/* Self-checking bench for bpt_top with a pin load model.
   Assumes bpt_checker is bound in alongside. */
`default_nettype none
module test_bpt_top
  import bpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i, sys_rst_i, counter_halt_set_i, counter_halt_clr_i, counter_reset_i;
  logic ext_tick_i, wrap_irq_enable_i, wrap_flag_clr_i, lclr;
  logic [2:0] clock_divider_select_i;
  bpt_cnt_t period_limit_value_i, match_wdata_i, count_o, c0, c1;
  logic [5:0] match_write_i, toggle_on_wrap_i, full_duty_enable_i;
  logic [5:0] match_irq_enable_i, match_flag_clr_i, match_flag_o, match_irq_o;
  logic [5:0] channel_pin_o, channel_pin_oe_o;
  logic [11:0] mode_select_i, compare_action_select_i;
  logic counter_halt_o, wrap_flag_o, wrap_irq_o;
  logic [2:0] pair_active_odd_o;
  logic [31:0] seed;
  int high [NUM_CH];
  int mv [NUM_CH];
  int mismatches, comparisons;
  bpt_top bpt_top_i (.*);
  bpt_load bpt_load_i (.core_clk_i(core_clk_i), .clr_i(lclr), .pin_i(channel_pin_o),
    .oe_i(channel_pin_oe_o), .high_o(high));
  initial begin
    core_clk_i = 0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc
  task wr(input int c, input bpt_cnt_t v);
    cyc(1);
    match_write_i <= 6'(1 << c);
    match_wdata_i <= v;
    cyc(1);
    match_write_i <= '0;
  endtask : wr
  // Bench model of high cycles in a 256-cycle period
  function automatic int exp_high(int c);
    if (c == 1 && mode_select_i[1]) return 256;
    if (full_duty_enable_i[c]) return compare_action_select_i[2*c] ? 0 : 256;
    if (!toggle_on_wrap_i[c]) return compare_action_select_i[2*c] ? 256 : 0;
    return compare_action_select_i[2*c] ? 256 - mv[c] : mv[c];
  endfunction : exp_high
  // Settling covers the two periods a late write may spoil
  task measure(input string name);
    cyc(3 * 256);
    lclr <= 1;
    cyc(1);
    lclr <= 0;
    cyc(256);
    #1;
    for (int c = 0; c < NUM_CH; c++) chk(high[c], exp_high(c));
    $display("test %s done", name);
  endtask : measure
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Waits for a flag, wrap flag for a negative index; running out ends the run as a failure
  task wait_set(input int sel);
    for (int i = 0; i < 300 && (sel < 0 ? wrap_flag_o : match_flag_o[sel]) !== 1'b1; i++) cyc(1);
    if ((sel < 0 ? wrap_flag_o : match_flag_o[sel]) !== 1'b1) begin
      mismatches++;
      print_verdict;
    end
  endtask : wait_set
  initial begin
    {sys_rst_i, lclr, match_irq_enable_i} = {1'b1, 1'b0, 6'h3f};
    {counter_halt_set_i, counter_halt_clr_i, counter_reset_i, ext_tick_i} = '0;
    {wrap_irq_enable_i, wrap_flag_clr_i, clock_divider_select_i} = {2'b10, 3'h0};
    {period_limit_value_i, match_wdata_i, match_write_i, match_flag_clr_i} = '0;
    {toggle_on_wrap_i, full_duty_enable_i, mode_select_i, compare_action_select_i} = '0;
    {mismatches, comparisons, seed} = {32'h0, 32'h0, 32'ha34c};
    cyc(8);
    sys_rst_i <= 0;
    cyc(1);
    counter_reset_i <= 1;
    cyc(1);
    counter_reset_i <= 0;
    period_limit_value_i <= 16'h00ff;
    for (int c = 0; c < NUM_CH; c++) begin
      seed = lfsr_next(seed);
      mv[c] = int'(seed % 254) + 1;
      wr(c, 16'(mv[c]));
    end
    mode_select_i <= 12'h555;
    compare_action_select_i <= 12'hEEE;
    toggle_on_wrap_i <= 6'h3f;
    #1;
    chk(counter_halt_o, 1);
    counter_halt_clr_i <= 1;
    cyc(1);
    counter_halt_clr_i <= 0;
    measure("single");
    chk(match_irq_o[0], 1);
    mode_select_i <= 12'h557;
    measure("linked even");
    chk(channel_pin_oe_o[1], 0);
    // Unbuffered updates timed from the events: shorter after a match, longer after a wrap
    match_flag_clr_i <= 6'h08;
    cyc(1);
    match_flag_clr_i <= '0;
    cyc(1);
    wait_set(3);
    mv[3] = (mv[3] + 1) / 2;
    wr(3, 16'(mv[3]));
    wrap_flag_clr_i <= 1;
    cyc(1);
    wrap_flag_clr_i <= 0;
    cyc(1);
    wait_set(-1);
    mv[5] = (mv[5] + 255) / 2;
    wr(5, 16'(mv[5]));
    mv[0] = 77;
    wr(1, 16'h004d);
    measure("linked odd");
    chk(pair_active_odd_o[0], 1);
    toggle_on_wrap_i[2] <= 0;
    full_duty_enable_i[5:4] <= 2'b11;
    measure("zero full");
    chk({wrap_flag_o, wrap_irq_o}, 2'b11);
    for (int i = 0; i < 300 && count_o !== 16'h0010; i++) cyc(1);
    if (count_o !== 16'h0010) begin
      mismatches++;
      print_verdict;
    end
    wrap_flag_clr_i <= 1;
    cyc(1);
    wrap_flag_clr_i <= 0;
    counter_halt_set_i <= 1;
    counter_reset_i <= 1;
    cyc(4);
    #1;
    chk({counter_halt_o, count_o, wrap_flag_o}, {1'b1, 16'h0000, 1'b0});
    {counter_halt_set_i, counter_reset_i, counter_halt_clr_i} <= 3'b001;
    period_limit_value_i <= 16'hffff;
    for (int k = 0; k < 8; k++) begin
      clock_divider_select_i <= 3'(k);
      cyc(3);
      counter_halt_clr_i <= 0;
      c0 = count_o;
      if (k == 7) repeat (10) begin
        cyc(1);
        ext_tick_i <= !ext_tick_i;
      end
      cyc(k == 7 ? 3 : 128);
      c1 = count_o;
      chk(c1 - c0, k == 7 ? 5 : 128 >> k);
    end
    print_verdict;
  end
endmodule : test_bpt_top
`default_nettype wire
